// ---- shared/ocd_cfg.svh ----
/*
 Constants for the display configuration command decoder: opcodes,
 reset values and parameter counts.
 Assumes inclusion by both ends of the link.
*/
// Notes on behaviour
// RULE1: select low is opcode, high is parameter.
// RULE2: opcode A9 leaves partial display mode.
// RULE3: AB bit 0 picks supply, reset 1.
// RULE4: AE sleeps, AF wakes; opcode bit 0.
// RULE5: B1 nibbles set phase one and two.
// RULE6: B3 low nibble divides clock; codes above ten invalid.
// RULE7: B3 high nibble sets oscillator frequency.
// RULE8: B5 sets two aux pin modes, reset 10.
// RULE9: B6 sets second precharge, reset 1000.
// RULE10: B8 takes fifteen gray pulse widths.
// RULE11: Host loads strictly increasing widths, first nonzero.
// RULE12: Host sends 00 after loading table.
// RULE13: Opcode 00 activates loaded gray table.
// RULE14: B9 selects built-in linear gray table.
// RULE15: BB sets precharge voltage, reset 17.
// RULE16: BE sets deselect level, reset 04.
// RULE17: C1 sets contrast current, reset 7f.
// RULE18: C7 sets master scale, reset maximum.
// RULE19: CA sets multiplex ratio N+1, reset 127.
// RULE20: FD bit 2 locks or unlocks, reset 12.
// RULE21: Locked decoder accepts only FD and parameter.
// RULE22: Decoder counts parameters, then awaits opcode.
`ifndef OCD_CFG_SVH
`define OCD_CFG_SVH
`define OCD_OP_GRAY_EN    8'h00
`define OCD_OP_PART_EXIT  8'ha9
`define OCD_OP_SUPPLY     8'hab
`define OCD_OP_SLEEP_ON   8'hae
`define OCD_OP_SLEEP_OFF  8'haf
`define OCD_OP_PHASE      8'hb1
`define OCD_OP_CLKDIV     8'hb3
`define OCD_OP_AUX        8'hb5
`define OCD_OP_PRECH2     8'hb6
`define OCD_OP_GRAY_TBL   8'hb8
`define OCD_OP_GRAY_LIN   8'hb9
`define OCD_OP_PRECH_V    8'hbb
`define OCD_OP_DESEL      8'hbe
`define OCD_OP_CONTRAST   8'hc1
`define OCD_OP_MASTER     8'hc7
`define OCD_OP_MUX        8'hca
`define OCD_OP_LOCK       8'hfd
`define OCD_GRAY_COUNT    4'hf
`define OCD_LOCK_BIT      2
`define OCD_RST_SUPPLY    1'h1
`define OCD_RST_PHASE     8'h00
`define OCD_RST_CLKDIV    8'h00
`define OCD_RST_AUX       2'h2
`define OCD_RST_PRECH2    4'h8
`define OCD_RST_PRECH_V   5'h17
`define OCD_RST_DESEL     4'h4
`define OCD_RST_CONTRAST  8'h7f
`define OCD_RST_MASTER    4'hf
`define OCD_RST_MUX       7'h7f
`define OCD_RST_LOCK      8'h12
`define OCD_MUX_MIN       7'h0f
`define OCD_CLKDIV_MAX    4'ha
`define OCD_LIN_STEP      8'h08
`define OCD_OFS_SEND      8'h00
`define OCD_OFS_STAT      8'h04
`endif

// ---- shared/ocd_pkg.sv ----
/*
 Types shared by both ends of the command link.
 Assumes ocd_cfg.svh is on the include path.
*/
package ocd_pkg;
   typedef logic [7:0] ocd_byte_t;
   typedef enum logic [1:0] {OCD_AUX_IN_OFF, OCD_AUX_IN_ON, OCD_AUX_LOW, OCD_AUX_HIGH} ocd_aux_mode_t;
endpackage

// ---- shared/ocd_link_if.sv ----
/*
 Byte link between host and decoder: one strobe per byte with its
 data/command select. Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface ocd_link_if (input wire logic pclk);
   logic       byte_valid;
   logic       data_sel;
   logic [7:0] byte_data;
   logic       byte_ready;
   modport host   (output byte_valid, output data_sel, output byte_data, input byte_ready);
   modport device (input byte_valid, input data_sel, input byte_data, output byte_ready);
endinterface

// ---- rtl/ocd_host.sv ----
/*
 Host end: APB slave with a send register; each send write queues one byte
 with its select onto the link. Assumes a single clock and APB master.
*/
`timescale 1ns/10ps
`include "ocd_cfg.svh"
module ocd_host
   import ocd_pkg::*;
(
   input  wire logic        pclk,    // Clock.
   input  wire logic        presetn, // Async reset, active low.
   input  wire logic        psel,    // APB select.
   input  wire logic        penable, // APB enable.
   input  wire logic        pwrite,  // APB direction.
   input  wire logic [7:0]  paddr,   // APB byte address.
   input  wire logic [31:0] pwdata,  // APB write data.
   output logic      [31:0] prdata,  // APB read data.
   output logic             pready,  // APB ready.
   output logic             pslverr, // APB error.
   ocd_link_if.host         link     // Link to decoder.
);
   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   localparam logic [7:0] SEND_OFS = `OCD_OFS_SEND;
   localparam logic [7:0] STAT_OFS = `OCD_OFS_STAT;
   logic valid_reg;
   logic sel_reg;
   logic [7:0] data_reg;
   logic rdy_reg;
   logic err_reg;
   logic [31:0] rd_reg;
   wire hit_send = paddr == SEND_OFS;
   wire hit_stat = paddr == STAT_OFS;
   // A send while a byte is still pending waits for the link to clear.
   wire blocked = pwrite && hit_send && valid_reg;
   wire answer = psel && !rdy_reg && !blocked;
   // The byte is queued only at the edge that completes the transfer.
   wire take_send = psel && penable && rdy_reg && pwrite && hit_send;
   wire [31:0] rd_val = hit_stat ? {31'h0, valid_reg} : 32'h0;
   assign prdata = rd_reg;
   assign pready = rdy_reg;
   assign pslverr = err_reg;
   assign link.byte_valid = valid_reg;
   assign link.data_sel = sel_reg;
   assign link.byte_data = data_reg;
   // ----------------------------------------
   // Bus answer, registered
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_reg <= 1'b0;
         err_reg <= 1'b0;
         rd_reg  <= 32'h0;
      end else begin
         rdy_reg <= answer;
         err_reg <= answer && !(hit_send || hit_stat);
         rd_reg  <= rd_val;
      end
   end
   // ----------------------------------------
   // Byte strobe, held until the decoder takes it
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_reg <= 1'b0;
         sel_reg   <= 1'b0;
         data_reg  <= 8'h00;
      end else if (take_send) begin
         valid_reg <= 1'b1;
         sel_reg   <= pwdata[8]; // RULE1
         data_reg  <= pwdata[7:0];
      end else if (link.byte_ready) begin
         valid_reg <= 1'b0;
      end
   end
endmodule

// ---- rtl/ocd_decoder.sv ----
/*
 Device end: decodes opcode and parameter bytes into configuration
 outputs. Assumes the host holds each byte until byte_ready.
*/
`timescale 1ns/10ps
`include "ocd_cfg.svh"
module ocd_decoder
   import ocd_pkg::*;
(
   input  wire logic        pclk,                   // Clock.
   input  wire logic        presetn,                // Async reset, active low.
   ocd_link_if.device       link,                   // Link from host.
   output logic             partial_exit_pulse,     // Partial mode left.
   output logic             internal_regulator,     // On-chip supply on.
   output logic             panel_on,               // Awake, panel driven.
   output logic [3:0]       first_phase_length,     // Phase one code.
   output logic [3:0]       second_phase_length,    // Phase two code.
   output logic [3:0]       clock_divide_log2,      // Clock divide power.
   output logic [3:0]       osc_freq_code,          // Oscillator trim.
   output ocd_aux_mode_t    aux_pin_zero,           // Aux pin zero mode.
   output ocd_aux_mode_t    aux_pin_one,            // Aux pin one mode.
   output logic [3:0]       second_precharge,       // Second precharge clocks.
   output logic [4:0]       precharge_level,        // Precharge voltage code.
   output logic [3:0]       common_deselect_level,  // Deselect level code.
   output logic [7:0]       contrast_current,       // Segment current step.
   output logic [3:0]       master_scale,           // Master scale k.
   output logic [6:0]       mux_ratio,              // Rows minus one.
   output logic             cmd_locked,             // Command lock.
   output logic [119:0]     gray_widths,            // Active widths, level 1 low.
   output logic             gray_custom             // Custom table active.
);
   // ----------------------------------------
   // Parameter sequencer
   // ----------------------------------------
   typedef enum {OCD_WAIT_OP, OCD_WAIT_PARAM} ocd_state_t;
   ocd_state_t state_reg;
   logic [7:0] op_reg;
   logic [3:0] left_reg;
   logic [7:0] staged_reg [15];
   logic [7:0] active_reg [15];
   logic [3:0] gidx_reg;
   logic [7:0] lock_reg;
   wire is_op = link.byte_valid && !link.data_sel; // RULE1
   wire is_par = link.byte_valid && link.data_sel; // RULE1
   wire locked = lock_reg[`OCD_LOCK_BIT];
   wire op_ok = is_op && (!locked || link.byte_data == `OCD_OP_LOCK); // RULE21
   wire par_ok = is_par && state_reg == OCD_WAIT_PARAM; // RULE21
   wire [7:0] d = link.byte_data;
   logic [3:0] need;
   always_comb begin
      unique case (d)
         `OCD_OP_GRAY_TBL: need = `OCD_GRAY_COUNT; // RULE10
         `OCD_OP_SUPPLY, `OCD_OP_PHASE, `OCD_OP_CLKDIV, `OCD_OP_AUX, `OCD_OP_PRECH2,
         `OCD_OP_PRECH_V, `OCD_OP_DESEL, `OCD_OP_CONTRAST, `OCD_OP_MASTER, `OCD_OP_MUX,
         `OCD_OP_LOCK: need = 4'h1;
         default: need = 4'h0;
      endcase
   end
   wire par_last = par_ok && left_reg == 4'h1;
   assign link.byte_ready = 1'b1;
   assign cmd_locked = locked;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= OCD_WAIT_OP;
         op_reg    <= 8'h00;
         left_reg  <= 4'h0;
         gidx_reg  <= 4'h0;
      end else if (op_ok) begin
         op_reg    <= d;
         left_reg  <= need;
         gidx_reg  <= 4'h0;
         state_reg <= (need != 4'h0) ? OCD_WAIT_PARAM : OCD_WAIT_OP; // RULE22
      end else if (par_ok) begin
         left_reg  <= left_reg - 4'h1;
         gidx_reg  <= gidx_reg + 4'h1;
         if (par_last) state_reg <= OCD_WAIT_OP; // RULE22
      end
   end
   // ----------------------------------------
   // Single-byte opcodes
   // ----------------------------------------
   wire op_part_exit = op_ok && d == `OCD_OP_PART_EXIT;
   wire op_sleep     = op_ok && d[7:1] == 7'(`OCD_OP_SLEEP_ON >> 1);
   wire op_gray_en   = op_ok && d == `OCD_OP_GRAY_EN;
   wire op_gray_lin  = op_ok && d == `OCD_OP_GRAY_LIN;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         partial_exit_pulse <= 1'b0;
         panel_on           <= 1'b0;
         gray_custom        <= 1'b0;
      end else begin
         partial_exit_pulse <= op_part_exit; // RULE2
         if (op_sleep) panel_on <= d[0]; // RULE4
         if (op_gray_en) gray_custom <= 1'b1; // RULE13
         if (op_gray_lin) gray_custom <= 1'b0; // RULE14
      end
   end
   // ----------------------------------------
   // Parameter registers
   // ----------------------------------------
   wire [7:0] op           = op_reg;
   wire       par_supply   = par_ok && op == `OCD_OP_SUPPLY;
   wire       par_phase    = par_ok && op == `OCD_OP_PHASE;
   wire       par_clkdiv   = par_ok && op == `OCD_OP_CLKDIV;
   wire       par_aux      = par_ok && op == `OCD_OP_AUX;
   wire       par_prech2   = par_ok && op == `OCD_OP_PRECH2;
   wire       par_prech_v  = par_ok && op == `OCD_OP_PRECH_V;
   wire       par_desel    = par_ok && op == `OCD_OP_DESEL;
   wire       par_contrast = par_ok && op == `OCD_OP_CONTRAST;
   wire       par_master   = par_ok && op == `OCD_OP_MASTER;
   wire       par_mux      = par_ok && op == `OCD_OP_MUX;
   wire       par_lock     = par_ok && op == `OCD_OP_LOCK;
   wire       par_gray     = par_ok && op == `OCD_OP_GRAY_TBL;
   wire       div_valid    = d[3:0] <= `OCD_CLKDIV_MAX; // RULE6
   wire       mux_valid    = d[6:0] >= `OCD_MUX_MIN; // RULE19
   // ----------------------------------------
   // One register per setting
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         internal_regulator <= `OCD_RST_SUPPLY;
      end else if (par_supply) begin
         internal_regulator <= d[0]; // RULE3
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {second_phase_length, first_phase_length} <= `OCD_RST_PHASE;
      end else if (par_phase) begin
         {second_phase_length, first_phase_length} <= d; // RULE5
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {osc_freq_code, clock_divide_log2} <= `OCD_RST_CLKDIV;
      end else if (par_clkdiv) begin
         osc_freq_code <= d[7:4]; // RULE7
         if (div_valid) clock_divide_log2 <= d[3:0]; // RULE6
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_pin_zero <= ocd_aux_mode_t'(`OCD_RST_AUX);
         aux_pin_one  <= ocd_aux_mode_t'(`OCD_RST_AUX);
      end else if (par_aux) begin
         aux_pin_zero <= ocd_aux_mode_t'(d[1:0]); // RULE8
         aux_pin_one  <= ocd_aux_mode_t'(d[3:2]); // RULE8
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_precharge <= `OCD_RST_PRECH2;
      end else if (par_prech2) begin
         second_precharge <= d[3:0]; // RULE9
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         precharge_level <= `OCD_RST_PRECH_V;
      end else if (par_prech_v) begin
         precharge_level <= d[4:0]; // RULE15
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         common_deselect_level <= `OCD_RST_DESEL;
      end else if (par_desel) begin
         common_deselect_level <= d[3:0]; // RULE16
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         contrast_current <= `OCD_RST_CONTRAST;
      end else if (par_contrast) begin
         contrast_current <= d; // RULE17
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_scale <= `OCD_RST_MASTER;
      end else if (par_master) begin
         master_scale <= d[3:0]; // RULE18
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_ratio <= `OCD_RST_MUX;
      end else if (par_mux && mux_valid) begin
         mux_ratio <= d[6:0]; // RULE19
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_reg <= `OCD_RST_LOCK;
      end else if (par_lock) begin
         lock_reg <= d; // RULE20
      end
   end
   // ----------------------------------------
   // Gray table: staged on load, copied on enable
   // ----------------------------------------
   genvar g;
   for (g = 0; g < 15; g++) begin : gray
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            staged_reg[g] <= 8'h00;
            active_reg[g] <= 8'(g * `OCD_LIN_STEP);
         end else begin
            if (par_gray && gidx_reg == 4'(g)) staged_reg[g] <= d; // RULE10
            // The shown width is a flip-flop: staged table on enable, ramp on default.
            if (op_gray_en) active_reg[g] <= staged_reg[g]; // RULE13
            else if (op_gray_lin) active_reg[g] <= 8'(g * `OCD_LIN_STEP); // RULE14
         end
      end
      assign gray_widths[8*g +: 8] = active_reg[g];
   end
endmodule

// ---- testbench/ocd_link_properties.sv ----
/*
 Checker for the byte link and the decoder settings it drives.
 Assumes one clock and an instance beside the link interface.
*/
`timescale 1ns/10ps
module ocd_link_chk (
   input wire logic       pclk,               // Clock.
   input wire logic       presetn,            // Reset, active low.
   input wire logic       byte_valid,         // Byte offered.
   input wire logic       data_sel,           // Parameter select.
   input wire logic [7:0] byte_data,          // Byte value.
   input wire logic       byte_ready,         // Device ready.
   input wire logic       partial_exit_pulse, // Partial mode left.
   input wire logic       panel_on,           // Panel driven.
   input wire logic [3:0] clock_divide_log2,  // Divide power.
   input wire logic [7:0] contrast_current,   // Contrast step.
   input wire logic [6:0] mux_ratio,          // Rows minus one.
   input wire logic       cmd_locked,         // Lock state.
   input wire logic       gray_custom         // Custom table.
);
   wire op_take   = byte_valid && !data_sel && !cmd_locked;
   wire exit_take = op_take && byte_data == 8'ha9;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_tied_a: assert property (byte_ready) else $error("ready low");
   valid_single_a: assert property (byte_valid |=> !byte_valid) else $error("valid held");
   exit_pulse_a: assert property (exit_take |=> partial_exit_pulse) else $error("no exit pulse");
   exit_cause_a: assert property (partial_exit_pulse |-> $past(exit_take)) else $error("stray pulse");
   sleep_bit_a: assert property (op_take && byte_data[7:1] == 7'h57 |=> panel_on == $past(byte_data[0]))
      else $error("sleep wrong");
   lock_hold_a: assert property (cmd_locked |=> $stable(contrast_current) && $stable(mux_ratio))
      else $error("locked change");
   mux_floor_a: assert property (mux_ratio >= 7'h0f) else $error("mux low");
   div_ceil_a: assert property (clock_divide_log2 <= 4'ha) else $error("div high");
   lin_sel_a: assert property (op_take && byte_data == 8'hb9 |=> !gray_custom) else $error("linear");
   gray_en_a: assert property (op_take && byte_data == 8'h00 |=> gray_custom) else $error("custom");
   cover property (partial_exit_pulse);
   cover property ($rose(cmd_locked));
   cover property ($rose(gray_custom));
endmodule

// ---- testbench/tb_oled_config_command_decoder.sv ----
/*
 Self-checking bench: APB writes into the host end reach the decoder.
 Assumes the host end answers the APB transfer and forwards each byte.
*/
`timescale 1ns/10ps
module tb_oled_config_command_decoder
   import ocd_pkg::*;
;
   logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]    paddr = '0;
   logic [31:0]   pwdata = '0, prdata, rd;
   logic          pready, pslverr, er, pulse, rg, on, lk, gc;
   logic [3:0]    p1, p2, dv, os, pc, ds, ms;
   ocd_aux_mode_t a0, a1;
   logic [4:0]    pv;
   logic [7:0]    ct, m_ct;
   logic [6:0]    mx, m_mx;
   logic [119:0]  gw, ew;
   logic          m_rg, m_on, m_lk;
   logic [3:0]    m_p1, m_p2, m_dv, m_os, m_pc, m_ds, m_ms;
   logic [1:0]    m_a0, m_a1;
   logic [4:0]    m_pv;
   logic [7:0]    ops [14] = '{8'hab, 8'hae, 8'haf, 8'hb1, 8'hb3, 8'hb5, 8'hb6, 8'hbb, 8'hbe, 8'hc1,
                                8'hc7, 8'hca, 8'ha9, 8'hfd};
   logic [15:0]   corner [9] = '{16'hb30a, 16'hb30b, 16'hca0e, 16'hca0f, 16'hfd16, 16'hc133, 16'haf00,
                                 16'hfd12, 16'haf00};
   int            mismatches = 0, comparisons = 0, cycles = 0;
   wire [54:0]    seen = {rg, on, p1, p2, dv, os, a0, a1, pc, pv, ds, ct, ms, mx, lk};
   wire [54:0]    expv = {m_rg, m_on, m_p1, m_p2, m_dv, m_os, m_a0, m_a1, m_pc, m_pv, m_ds, m_ct, m_ms, m_mx, m_lk};

   ocd_link_if link_bus (.pclk(pclk));
   ocd_host u_ocd_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_bus));
   ocd_decoder u_ocd_decoder (.pclk(pclk), .presetn(presetn), .link(link_bus), .partial_exit_pulse(pulse),
      .internal_regulator(rg), .panel_on(on), .first_phase_length(p1), .second_phase_length(p2),
      .clock_divide_log2(dv), .osc_freq_code(os), .aux_pin_zero(a0), .aux_pin_one(a1), .second_precharge(pc),
      .precharge_level(pv), .common_deselect_level(ds), .contrast_current(ct), .master_scale(ms),
      .mux_ratio(mx), .cmd_locked(lk), .gray_widths(gw), .gray_custom(gc));
   ocd_link_chk u_chk (.pclk(pclk), .presetn(presetn), .byte_valid(link_bus.byte_valid),
      .data_sel(link_bus.data_sel), .byte_data(link_bus.byte_data), .byte_ready(link_bus.byte_ready),
      .partial_exit_pulse(pulse), .panel_on(on), .clock_divide_log2(dv), .contrast_current(ct),
      .mux_ratio(mx), .cmd_locked(lk), .gray_custom(gc));

   always #4 pclk = ~pclk;

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [119:0] got, input logic [119:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic send(input logic [7:0] b, input logic sel);
      apb(1, 8'h00, {23'h0, sel, b});
   endtask

   // Reference model of the settings; a locked decoder only hears the lock opcode.
   task automatic model(input logic [7:0] o, input logic [7:0] p);
      if (!m_lk || o == 8'hfd) begin
         case (o)
            8'hab: m_rg = p[0];
            8'hae, 8'haf: m_on = o[0];
            8'hb1: {m_p2, m_p1} = p;
            8'hb3: begin
               m_os = p[7:4];
               if (p[3:0] <= 4'ha) m_dv = p[3:0];
            end
            8'hb5: {m_a1, m_a0} = p[3:0];
            8'hb6: m_pc = p[3:0];
            8'hbb: m_pv = p[4:0];
            8'hbe: m_ds = p[3:0];
            8'hc1: m_ct = p;
            8'hc7: m_ms = p[3:0];
            8'hca: if (p[6:0] >= 7'h0f) m_mx = p[6:0];
            8'hfd: m_lk = p[2];
            default: ;
         endcase
      end
   endtask

   task automatic pair(input logic [7:0] o, input logic [7:0] p);
      send(o, 0);
      send(p, 1);
      model(o, p);
      repeat (2) @(posedge pclk);
      chk(seen, expv);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      void'($urandom(32'he893));
      {m_rg, m_on, m_p1, m_p2, m_dv, m_os} = {2'b10, 16'h0000};
      {m_a0, m_a1, m_pc, m_pv, m_ds} = {4'ha, 4'h8, 5'h17, 4'h4};
      {m_ct, m_ms, m_mx, m_lk} = {8'h7f, 4'hf, 7'h7f, 1'b0};
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk(seen, expv);
      $display("reset values done");
      foreach (corner[i]) pair(corner[i][15:8], corner[i][7:0]);
      for (int i = 0; i < 60; i++) pair(ops[$urandom % 14], 8'($urandom));
      $display("settings done");
      pair(8'hfd, 8'h12);
      send(8'hb8, 0);
      send(8'h01, 1);
      pair(8'hc1, 8'h55);
      send(8'hb8, 0);
      for (int g = 0; g < 15; g++) begin
         ew[8*g +: 8] = 8'(5 + g * 12);
         send(ew[8*g +: 8], 1);
      end
      send(8'h00, 0);
      repeat (2) @(posedge pclk);
      chk(gw, ew);
      chk(gc, 1);
      send(8'hb9, 0);
      for (int g = 0; g < 15; g++) ew[8*g +: 8] = 8'(g * 8);
      repeat (2) @(posedge pclk);
      chk(gw, ew);
      $display("gray table done");
      apb(0, 8'h08, 0);
      chk(er, 1);
      apb(0, 8'h04, 0);
      chk({er, rd[0]}, 0);
      $display("register bus done");
      report_and_stop();
   end
endmodule
